// ===== verilog/debug_flash_program_regs.sv
// Purpose: device-side registers of the two-wire debug and programming link
// Assumes: link clock and data arrive from outside and are synchronised here
// Notes: frames are accepted only while the core is halted
`timescale 1ns/10ps
`default_nettype none

module debug_flash_program_regs
    import debug_flash_pkg::*;
#(
    parameter logic [7:0] PART_IDENTITY = 8'h5A // arbitrary identity value
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_core_halted,
    input wire logic [7:0] i_silicon_revision,
    input wire logic i_link_clk,
    input wire logic i_link_data,
    output logic o_link_data,
    output logic o_link_data_oe,
    output logic o_reset_pin_is_link,
    output logic o_stall_all,
    output logic o_prog_enabled,
    output logic o_flash_op_stb,
    output flash_op_e o_flash_op,
    output logic o_flash_arg_stb,
    output logic [7:0] o_flash_arg,
    input wire logic i_flash_resp_valid,
    input wire logic [7:0] i_flash_resp,
    input wire logic i_flash_done
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] clk_sync_q, clk_sync_d;   // [0] is the metastable stage
    logic [1:0] data_sync_q, data_sync_d; // [0] is the metastable stage
    logic link_rise;                      // rising edge of link clock
    logic link_din;                       // synchronised data level

    // shift pins in; stage 0 only ever feeds stage 1
    always_comb begin
        clk_sync_d = {clk_sync_q[1:0], i_link_clk};
        data_sync_d = {data_sync_q[0], i_link_data};
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            clk_sync_q <= 3'h0;
            data_sync_q <= 2'h3;
        end else begin
            clk_sync_q <= clk_sync_d;
            data_sync_q <= data_sync_d;
        end
    end

    // edge found between stages 1 and 2, never from stage 0
    assign link_rise = clk_sync_q[1] && !clk_sync_q[2];
    assign link_din = data_sync_q[1];

    // ----------------------------------------------------------------
    // revision capture after reset
    // ----------------------------------------------------------------
    logic [7:0] rev_q, rev_d; // silicon revision as seen by the link
    logic rev_taken_q, rev_taken_d;

    // straps are caught once, after release, never loaded by the reset itself
    always_comb begin
        rev_d = rev_q;
        rev_taken_d = 1'b1;
        if (!rev_taken_q) begin
            rev_d = i_silicon_revision; // [RULE3]
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rev_q <= REVISION_RESET;
            rev_taken_q <= 1'b0;
        end else begin
            rev_q <= rev_d;
            rev_taken_q <= rev_taken_d;
        end
    end

    // ----------------------------------------------------------------
    // link frame engine and registers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LINK_IDLE, LINK_INSTR, LINK_WDATA, LINK_RDATA} link_state_e;
    typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_ARMED, UNLOCK_OPEN} unlock_e;

    link_state_e state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;  // bits taken in this phase
    logic [1:0] ins_q, ins_d;          // instruction, lsb first
    logic [7:0] shift_q, shift_d;      // data shifter, lsb first
    logic [7:0] sel_q, sel_d;          // register select
    logic [7:0] ctrl_q, ctrl_d;        // last unlock control write
    unlock_e unlock_q, unlock_d;
    logic oe_q, oe_d;                  // link data driven by device
    logic wr_stb_q, wr_stb_d;          // program data write pulse
    logic [7:0] wr_byte_q, wr_byte_d;
    logic [7:0] write_byte;            // byte complete on this edge
    logic commit;                      // write frame finishes now

    prog_data_if pd ();

    // value returned for a data read of the selected register
    function automatic logic [7:0] read_value(input logic [7:0] sel,
                                              input logic [7:0] rev,
                                              input logic [7:0] ctrl,
                                              input logic [7:0] pdat);
        unique case (sel)
            SEL_PART_IDENTITY: read_value = PART_IDENTITY; // [RULE2]
            SEL_SILICON_REVISION: read_value = rev;        // [RULE3]
            SEL_PROGRAM_UNLOCK: read_value = ctrl;
            SEL_PROGRAM_DATA: read_value = pdat;           // [RULE6]
            default: read_value = 8'h00;
        endcase
    endfunction : read_value

    assign write_byte = {link_din, shift_q[7:1]};
    assign commit = (state_q == LINK_WDATA) && link_rise && (bit_cnt_q == DATA_LAST_BIT);

    // next-state for the frame engine and every register behind it
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        ins_d = ins_q;
        shift_d = shift_q;
        sel_d = sel_q;
        ctrl_d = ctrl_q;
        unlock_d = unlock_q;
        oe_d = oe_q;
        wr_stb_d = 1'b0;
        wr_byte_d = wr_byte_q;
        if (!i_core_halted) begin
            // pins belong to the application: drop any frame in flight
            state_d = LINK_IDLE; // [RULE11]
            oe_d = 1'b0;
        end else if (link_rise) begin
            unique case (state_q)
                LINK_IDLE: begin
                    // start bit is a low level on a rising edge
                    if (!link_din) begin
                        state_d = LINK_INSTR;
                        bit_cnt_d = 4'h0;
                    end
                end
                LINK_INSTR: begin
                    ins_d = {link_din, ins_q[1]};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == INSTR_LAST_BIT) begin
                        bit_cnt_d = 4'h0;
                        if ({link_din, ins_q[1]} == INS_SELECT_READ) begin
                            shift_d = sel_q;
                            oe_d = 1'b1;
                            state_d = LINK_RDATA;
                        end else if ({link_din, ins_q[1]} == INS_DATA_READ) begin
                            shift_d = read_value(sel_q, rev_q, ctrl_q, pd.rd_byte); // [RULE1]
                            oe_d = 1'b1;
                            state_d = LINK_RDATA;
                        end else begin
                            state_d = LINK_WDATA;
                        end
                    end
                end
                LINK_WDATA: begin
                    shift_d = write_byte;
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == DATA_LAST_BIT) begin
                        state_d = LINK_IDLE;
                    end
                end
                LINK_RDATA: begin
                    // host sampled the current bit on this edge
                    shift_d = {1'b0, shift_q[7:1]};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == DATA_LAST_BIT) begin
                        oe_d = 1'b0;
                        state_d = LINK_IDLE;
                    end
                end
            endcase
        end
        if (commit && i_core_halted) begin
            if (ins_q == INS_SELECT_WRITE) begin
                sel_d = write_byte; // [RULE1]
            end else begin
                // identity and revision have no storage, so writes fall away
                unique case (sel_q)
                    SEL_PROGRAM_UNLOCK: begin
                        ctrl_d = write_byte;
                        // once open, only a system reset closes it
                        if (unlock_q != UNLOCK_OPEN) begin // [RULE5]
                            if (unlock_q == UNLOCK_ARMED && write_byte == UNLOCK_KEY_SECOND) begin
                                unlock_d = UNLOCK_OPEN; // [RULE4]
                            end else if (write_byte == UNLOCK_KEY_FIRST) begin
                                unlock_d = UNLOCK_ARMED; // [RULE4]
                            end else begin
                                unlock_d = UNLOCK_IDLE;
                            end
                        end
                    end
                    SEL_PROGRAM_DATA: begin
                        wr_stb_d = 1'b1; // [RULE6]
                        wr_byte_d = write_byte;
                    end
                    default: begin
                        ctrl_d = ctrl_q; // [RULE14]
                    end
                endcase
            end
        end
    end

    // registers for the frame engine
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= LINK_IDLE;
            bit_cnt_q <= 4'h0;
            ins_q <= 2'h0;
            shift_q <= 8'h00;
            sel_q <= SELECT_RESET;
            ctrl_q <= UNLOCK_CTRL_RESET;
            unlock_q <= UNLOCK_IDLE;
            oe_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_byte_q <= PROGRAM_DATA_RESET;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            ins_q <= ins_d;
            shift_q <= shift_d;
            sel_q <= sel_d;
            ctrl_q <= ctrl_d;
            unlock_q <= unlock_d;
            oe_q <= oe_d;
            wr_stb_q <= wr_stb_d;
            wr_byte_q <= wr_byte_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs and flash command decoder
    // ----------------------------------------------------------------
    assign pd.wr_stb = wr_stb_q;
    assign pd.wr_byte = wr_byte_q;
    assign pd.unlocked = (unlock_q == UNLOCK_OPEN);

    assign o_link_data = shift_q[0];
    assign o_link_data_oe = oe_q && i_core_halted;           // [RULE11]
    assign o_reset_pin_is_link = i_core_halted;              // [RULE11]
    // programming keeps the core stalled too, as it needs a reset to resume
    assign o_stall_all = i_core_halted || (unlock_q == UNLOCK_OPEN); // [RULE10]
    assign o_prog_enabled = (unlock_q == UNLOCK_OPEN);

    flash_cmd_decoder u_decoder (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .bus(pd.decoder),
        .o_flash_op_stb(o_flash_op_stb),
        .o_flash_op(o_flash_op),
        .o_flash_arg_stb(o_flash_arg_stb),
        .o_flash_arg(o_flash_arg),
        .i_flash_resp_valid(i_flash_resp_valid),
        .i_flash_resp(i_flash_resp),
        .i_flash_done(i_flash_done)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence unlock_write(logic [7:0] key);
        commit && ins_q == INS_DATA_WRITE && sel_q == SEL_PROGRAM_UNLOCK
        && write_byte == key && i_core_halted;
    endsequence

    chk_unlock_sequence: assert property ( // [RULE4]
        (unlock_q == UNLOCK_ARMED) ##0 unlock_write(UNLOCK_KEY_SECOND)
        |=> o_prog_enabled)
        else $error("unlock sequence did not enable programming");
    chk_no_early_unlock: assert property ( // [RULE4]
        $rose(o_prog_enabled) |-> $past(unlock_q) == UNLOCK_ARMED)
        else $error("programming enabled without first key");
    chk_unlock_sticky: assert property ( // [RULE5]
        o_prog_enabled |=> o_prog_enabled)
        else $error("programming mode left without reset");
    chk_select_load: assert property ( // [RULE1]
        (commit && ins_q == INS_SELECT_WRITE && i_core_halted)
        |=> sel_q == $past(write_byte))
        else $error("select register not loaded");
    chk_identity_read: assert property ( // [RULE2]
        (state_q == LINK_INSTR && link_rise && i_core_halted
         && bit_cnt_q == INSTR_LAST_BIT && {link_din, ins_q[1]} == INS_DATA_READ
         && sel_q == SEL_PART_IDENTITY)
        |=> shift_q == PART_IDENTITY && o_link_data_oe)
        else $error("identity read returned wrong value");
    chk_revision_fixed: assert property ( // [RULE14]
        rev_taken_q |=> $stable(rev_q))
        else $error("revision changed after capture");
    chk_halt_stall: assert property ( // [RULE10]
        i_core_halted |-> o_stall_all)
        else $error("halted core not stalled");
    chk_pin_borrow: assert property ( // [RULE11]
        o_link_data_oe |-> o_reset_pin_is_link ##0 state_q == LINK_RDATA)
        else $error("data pin driven outside a halted read");

endmodule : debug_flash_program_regs

`default_nettype wire

// ===== verilog/debug_flash_pkg.sv
// Purpose: shared constants and types for the debug flash programming registers
// Assumes: 8-bit link registers selected through a register select byte
// Notes: link frames are sampled on rising edges of the host-driven link clock
//
// Notes on behaviour
// [RULE1] host loads select, then data commands target it
// [RULE2] select 0x00 reads fixed read-only part identity
// [RULE3] select 0x01 reads read-only silicon revision
// [RULE4] write 0x02 then 0x01 unlocks programming
// [RULE5] programming stays unlocked until system reset
// [RULE6] select 0xB4 carries commands, addresses, data
// [RULE7] code 0x06 block read, 0x07 block write
// [RULE8] code 0x08 page erase, 0x03 device erase
// [RULE9] host talks over the link while halted
// [RULE10] halted device stalls peripherals and program
// [RULE11] halted: reset pin clocks, shared pin data
// [RULE12] user input on data pin holds while halted
// [RULE13] application uses reset pin as input only
// [RULE14] writes to identity and revision are ignored
`default_nettype none

package debug_flash_pkg;

    // ----------------------------------------------------------------
    // register select values
    // ----------------------------------------------------------------
    localparam logic [7:0] SEL_PART_IDENTITY = 8'h00;
    localparam logic [7:0] SEL_SILICON_REVISION = 8'h01;
    localparam logic [7:0] SEL_PROGRAM_UNLOCK = 8'h02;
    localparam logic [7:0] SEL_PROGRAM_DATA = 8'hB4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] UNLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] PROGRAM_DATA_RESET = 8'h00;
    localparam logic [7:0] REVISION_RESET = 8'h00;

    // ----------------------------------------------------------------
    // unlock keys and flash command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h01;
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

    // ----------------------------------------------------------------
    // link frame layout: start bit low, 2 instruction bits, 8 data bits
    // ----------------------------------------------------------------
    localparam logic [1:0] INS_DATA_READ = 2'h0;
    localparam logic [1:0] INS_DATA_WRITE = 2'h1;
    localparam logic [1:0] INS_SELECT_READ = 2'h2;
    localparam logic [1:0] INS_SELECT_WRITE = 2'h3;
    localparam logic [3:0] INSTR_LAST_BIT = 4'h1;
    localparam logic [3:0] DATA_LAST_BIT = 4'h7;

    // decoded flash operation
    typedef enum logic [2:0] {
        FLASH_NONE,
        FLASH_BLOCK_READ,
        FLASH_BLOCK_WRITE,
        FLASH_PAGE_ERASE,
        FLASH_DEVICE_ERASE
    } flash_op_e;

endpackage : debug_flash_pkg

`default_nettype wire

// ===== verilog/prog_data_if.sv
// Purpose: carries program data register traffic between link logic and decoder
// Assumes: all signals on the core clock
// Notes: wr_stb is a one-cycle pulse with wr_byte valid alongside
`timescale 1ns/10ps
`default_nettype none

interface prog_data_if;
    logic wr_stb;        // host wrote the program data register
    logic [7:0] wr_byte; // byte written by the host
    logic unlocked;      // programming mode is enabled
    logic [7:0] rd_byte; // current program data register contents

    modport link (output wr_stb, output wr_byte, output unlocked, input rd_byte);
    modport decoder (input wr_stb, input wr_byte, input unlocked, output rd_byte);
endinterface : prog_data_if

`default_nettype wire

// ===== verilog/flash_cmd_decoder.sv
// Purpose: holds the program data register and decodes flash commands
// Assumes: host writes arrive as single-cycle strobes on the core clock
// Notes: commands are acted on only while programming is unlocked
`timescale 1ns/10ps
`default_nettype none

module flash_cmd_decoder
    import debug_flash_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    prog_data_if.decoder bus,
    output logic o_flash_op_stb,
    output flash_op_e o_flash_op,
    output logic o_flash_arg_stb,
    output logic [7:0] o_flash_arg,
    input wire logic i_flash_resp_valid,
    input wire logic [7:0] i_flash_resp,
    input wire logic i_flash_done
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic {WAIT_CMD, TAKE_ARGS} dec_state_e;
    dec_state_e state_q, state_d;
    logic [7:0] data_q, data_d;       // program data register
    logic op_stb_q, op_stb_d;
    flash_op_e op_q, op_d;
    logic arg_stb_q, arg_stb_d;
    logic [7:0] arg_q, arg_d;

    // maps a written code onto a flash operation
    function automatic flash_op_e decode(input logic [7:0] code);
        unique case (code)
            CMD_BLOCK_READ: decode = FLASH_BLOCK_READ;     // [RULE7]
            CMD_BLOCK_WRITE: decode = FLASH_BLOCK_WRITE;   // [RULE7]
            CMD_PAGE_ERASE: decode = FLASH_PAGE_ERASE;     // [RULE8]
            CMD_DEVICE_ERASE: decode = FLASH_DEVICE_ERASE; // [RULE8]
            default: decode = FLASH_NONE;
        endcase
    endfunction : decode

    // next-state: host write beats a flash response landing the same cycle
    always_comb begin
        state_d = state_q;
        data_d = data_q;
        op_stb_d = 1'b0;
        op_d = op_q;
        arg_stb_d = 1'b0;
        arg_d = arg_q;
        if (i_flash_done) begin
            state_d = WAIT_CMD;
        end
        if (i_flash_resp_valid) begin
            data_d = i_flash_resp; // [RULE6]
        end
        if (bus.wr_stb) begin
            data_d = bus.wr_byte; // [RULE6]
            if (bus.unlocked) begin
                if (state_q == WAIT_CMD) begin
                    op_d = decode(bus.wr_byte);
                    // unknown codes are stored but start nothing
                    if (decode(bus.wr_byte) != FLASH_NONE) begin
                        op_stb_d = 1'b1;
                        state_d = TAKE_ARGS;
                    end
                end else begin
                    // addresses and data bytes follow the command
                    arg_stb_d = 1'b1; // [RULE6]
                    arg_d = bus.wr_byte;
                end
            end
        end
    end

    // registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= WAIT_CMD;
            data_q <= PROGRAM_DATA_RESET;
            op_stb_q <= 1'b0;
            op_q <= FLASH_NONE;
            arg_stb_q <= 1'b0;
            arg_q <= PROGRAM_DATA_RESET;
        end else begin
            state_q <= state_d;
            data_q <= data_d;
            op_stb_q <= op_stb_d;
            op_q <= op_d;
            arg_stb_q <= arg_stb_d;
            arg_q <= arg_d;
        end
    end

    assign bus.rd_byte = data_q;
    assign o_flash_op_stb = op_stb_q;
    assign o_flash_op = op_q;
    assign o_flash_arg_stb = arg_stb_q;
    assign o_flash_arg = arg_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_read_write_decode: assert property ( // [RULE7]
        (bus.wr_stb && bus.unlocked && state_q == WAIT_CMD
         && (bus.wr_byte == CMD_BLOCK_READ || bus.wr_byte == CMD_BLOCK_WRITE))
        |=> o_flash_op_stb && (o_flash_op == FLASH_BLOCK_READ
                               || o_flash_op == FLASH_BLOCK_WRITE))
        else $error("block read or write code not decoded");
    chk_erase_decode: assert property ( // [RULE8]
        (bus.wr_stb && bus.unlocked && state_q == WAIT_CMD
         && bus.wr_byte == CMD_DEVICE_ERASE)
        |=> o_flash_op_stb && o_flash_op == FLASH_DEVICE_ERASE ##1 !o_flash_op_stb)
        else $error("device erase code not decoded");
    chk_locked_quiet: assert property ( // [RULE4]
        (bus.wr_stb && !bus.unlocked) |=> !o_flash_op_stb && !o_flash_arg_stb)
        else $error("flash activity while programming locked");
    chk_data_stored: assert property ( // [RULE6]
        bus.wr_stb |=> bus.rd_byte == $past(bus.wr_byte))
        else $error("program data write not held");

endmodule : flash_cmd_decoder

`default_nettype wire

// ===== verification/link_host_model.sv
// Purpose: host end of the two-wire debug link
// Assumes: link clock idles low, frames start when the bench calls
// Notes: a released data line reads high through the pull-up
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
    input wire logic i_dev_data,
    input wire logic i_dev_oe,
    output var logic o_link_clk,
    output wire logic o_link_wire
);
    logic host_oe = 1'b0; // host drives the data line
    logic host_bit = 1'b1; // level the host drives
    initial o_link_clk = 1'b0; // only the host drives the reset pin
    // wired data line: host, else device, else pull-up
    // no user input ever drives the shared line
    assign o_link_wire = host_oe ? host_bit : (i_dev_oe ? i_dev_data : 1'b1);
    // start, 2 instruction bits, 8 data bits, LSB first
    task automatic frame(input logic [1:0] ins, input logic [7:0] wr,
                         output logic [7:0] rd);
        logic [10:0] bits;
        bits = {wr, ins, 1'b0};
        rd = 8'h00;
        for (int i = 0; i < 11; i++) begin
            // reads hand the line over after the instruction
            host_oe = (i < 3) || ins[0];
            host_bit = bits[i];
            #62.5;
            if (i > 2) rd[i-3] = o_link_wire;
            o_link_clk = 1'b1;
            #62.5;
            o_link_clk = 1'b0;
        end
        host_oe = 1'b0;
    endtask : frame
endmodule : link_host_model
`default_nettype wire

// ===== verification/tb_debug_flash_program_regs.sv
// Purpose: self-checking bench for the debug flash registers
// Assumes: core halted except where a test releases it
// Notes: strobes land inside frames, so a watcher counts them
`timescale 1ns/10ps
`default_nettype none
module tb_debug_flash_program_regs;
    import debug_flash_pkg::*;
    localparam logic [7:0] ID = 8'hC3; // arbitrary identity value
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic halt = 1'b1; // frames are sent while halted
    logic [7:0] rev = 8'h3C;
    logic lclk, lwire, ddat, doe, pin, stall, prog, ostb, astb;
    logic rv = 1'b0;
    logic done = 1'b0;
    logic [7:0] arg, rd;
    logic [7:0] resp = 8'h00;
    flash_op_e op, last_op;
    int bad_count = 0;
    int tests_run = 0;
    int op_n = 0;
    int arg_n = 0;
    logic [7:0] codes [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
    flash_op_e ops [4] = '{FLASH_BLOCK_READ, FLASH_BLOCK_WRITE, FLASH_PAGE_ERASE,
                           FLASH_DEVICE_ERASE};
    always #4 i_clk = ~i_clk;
    link_host_model link_host_model_i (.i_dev_data(ddat), .i_dev_oe(doe),
        .o_link_clk(lclk), .o_link_wire(lwire));
    debug_flash_program_regs #(.PART_IDENTITY(ID)) debug_flash_program_regs_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_core_halted(halt), .i_silicon_revision(rev),
        .i_link_clk(lclk), .i_link_data(lwire), .o_link_data(ddat), .o_link_data_oe(doe),
        .o_reset_pin_is_link(pin), .o_stall_all(stall), .o_prog_enabled(prog),
        .o_flash_op_stb(ostb), .o_flash_op(op), .o_flash_arg_stb(astb), .o_flash_arg(arg),
        .i_flash_resp_valid(rv), .i_flash_resp(resp), .i_flash_done(done));
    // one-cycle strobes counted mid-cycle, where they have settled
    always @(negedge i_clk) begin
        if (ostb === 1'b1) begin
            op_n++;
            last_op = op;
        end
        if (astb === 1'b1) arg_n++;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    // one frame, started off the core edge, then time to commit
    task automatic xfer(input logic [1:0] ins, input logic [7:0] wr);
        @(posedge i_clk);
        #2.25;
        link_host_model_i.frame(ins, wr, rd);
        repeat (8) @(posedge i_clk);
    endtask : xfer
    task automatic reg_acc(input logic [1:0] ins, input logic [7:0] sel, input logic [7:0] v);
        xfer(INS_SELECT_WRITE, sel);
        xfer(ins, v);
    endtask : reg_acc
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk);
        reg_acc(INS_DATA_WRITE, SEL_PART_IDENTITY, 8'hFF);
        xfer(INS_DATA_READ, 8'h00);
        check("identity", rd, ID);
        reg_acc(INS_DATA_WRITE, SEL_SILICON_REVISION, 8'hFF);
        xfer(INS_DATA_READ, 8'h00);
        check("revision", rd, 8'h3C);
        xfer(INS_SELECT_READ, 8'h00);
        check("select", rd, SEL_SILICON_REVISION);
        // a command while locked is stored but starts nothing
        reg_acc(INS_DATA_WRITE, SEL_PROGRAM_DATA, CMD_BLOCK_READ);
        xfer(INS_DATA_READ, 8'h00);
        check("locked store", rd, CMD_BLOCK_READ);
        check("locked quiet", 8'(op_n), 8'h00);
        // a foreign byte between the keys spoils the sequence
        reg_acc(INS_DATA_WRITE, SEL_PROGRAM_UNLOCK, UNLOCK_KEY_FIRST);
        xfer(INS_DATA_WRITE, 8'h03);
        xfer(INS_DATA_WRITE, UNLOCK_KEY_SECOND);
        check("early unlock", 8'(prog), 8'h00);
        xfer(INS_DATA_WRITE, UNLOCK_KEY_FIRST);
        xfer(INS_DATA_WRITE, UNLOCK_KEY_SECOND);
        check("unlock", 8'(prog), 8'h01);
        xfer(INS_DATA_READ, 8'h00);
        check("unlock read", rd, UNLOCK_KEY_SECOND);
        foreach (codes[k]) begin
            reg_acc(INS_DATA_WRITE, SEL_PROGRAM_DATA, codes[k]);
            xfer(INS_DATA_WRITE, 8'hA5);
            check("op", 8'(last_op), 8'(ops[k]));
            @(posedge i_clk);
            done <= 1'b1;
            @(posedge i_clk);
            done <= 1'b0;
        end
        check("op count", 8'(op_n), 8'h04);
        check("arg count", 8'(arg_n), 8'h04);
        check("arg", arg, 8'hA5);
        @(posedge i_clk);
        rv <= 1'b1;
        resp <= 8'h9E;
        @(posedge i_clk);
        rv <= 1'b0;
        xfer(INS_DATA_READ, 8'h00);
        check("resp", rd, 8'h9E);
        halt <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("pin free", 8'(pin), 8'h00);
        check("sticky", 8'(stall & prog), 8'h01);
        // a frame while running must not reach the select register
        xfer(INS_SELECT_WRITE, SEL_PART_IDENTITY);
        halt <= 1'b1;
        xfer(INS_SELECT_READ, 8'h00);
        check("refused", rd, SEL_PROGRAM_DATA);
        halt <= 1'b0;
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        check("relock", 8'({prog, stall}), 8'h00);
        halt <= 1'b1;
        repeat (2) @(posedge i_clk);
        check("halted", 8'({pin, stall}), 8'h03);
        print_verdict();
    end
endmodule : tb_debug_flash_program_regs
`default_nettype wire
